// ### logic/irq_prio_pkg.sv
// constants, types and register map for the interrupt priority and vectoring block
// assumes an apb master on pclk and a cpu core that samples the vector outputs
package irq_prio_pkg;

    // --------------------------------------------------------------------
    // register map (byte addresses)
    // --------------------------------------------------------------------
    localparam logic [7:0] prio_misc_addr = 8'h00;
    localparam logic [7:0] status_addr    = 8'h04;
    localparam logic [7:0] vector_addr    = 8'h08;

    localparam logic [3:0] psel_reset     = 4'h5;
    localparam int         boot_bit       = 7;
    localparam int         special_mode_bit = 6;
    localparam int         mode_a_bit       = 5;
    localparam int         irv_bit        = 4;

    localparam int         n_maskable     = 15;

    // --------------------------------------------------------------------
    // vectors
    // --------------------------------------------------------------------
    localparam logic [15:0] vec_serial     = 16'hffd6;
    localparam logic [15:0] vec_spi        = 16'hffd8;
    localparam logic [15:0] vec_pa_edge    = 16'hffda;
    localparam logic [15:0] vec_pa_ovf     = 16'hffdc;
    localparam logic [15:0] vec_tovf       = 16'hffde;
    localparam logic [15:0] vec_ic4oc5     = 16'hffe0;
    localparam logic [15:0] vec_oc4        = 16'hffe2;
    localparam logic [15:0] vec_oc3        = 16'hffe4;
    localparam logic [15:0] vec_oc2        = 16'hffe6;
    localparam logic [15:0] vec_oc1        = 16'hffe8;
    localparam logic [15:0] vec_ic3        = 16'hffea;
    localparam logic [15:0] vec_ic2        = 16'hffec;
    localparam logic [15:0] vec_ic1        = 16'hffee;
    localparam logic [15:0] vec_rti        = 16'hfff0;
    localparam logic [15:0] vec_irq        = 16'hfff2;
    localparam logic [15:0] vec_xpin       = 16'hfff4;
    localparam logic [15:0] vec_swtrap     = 16'hfff6;
    localparam logic [15:0] vec_illegal    = 16'hfff8;
    localparam logic [15:0] vec_watchdog   = 16'hfffa;
    localparam logic [15:0] vec_clkmon     = 16'hfffc;
    localparam logic [15:0] vec_reset      = 16'hfffe;

    // maskable sources in default order, index 0 highest
    typedef enum logic [3:0] {
        src_irq, src_rti, src_ic1, src_ic2, src_ic3, src_oc1, src_oc2, src_oc3, src_oc4,
        src_ic4oc5, src_tovf, src_pa_ovf, src_pa_edge, src_spi, src_serial
    } mask_src_t;

    // serial requests and their enables
    typedef struct packed {
        logic tx_complete;
        logic tx_empty;
        logic idle_line;
        logic rx_overrun;
        logic rx_full;
    } serial_req_t;

    typedef struct packed {
        logic tx_complete_enable;
        logic tx_empty_enable;
        logic idle_line_enable;
        logic rx_event_enable;
    } serial_en_t;

    // non-maskable causes and traps
    typedef struct packed {
        logic reset_req;
        logic clock_fail;
        logic watchdog_timeout;
        logic nonmaskable_pin_interrupt;
        logic illegal_opcode;
        logic software_trap;
    } nmi_req_t;

    typedef struct packed {
        logic        valid;
        logic        is_xpin;
        logic [15:0] addr;
    } vector_t;

endpackage : irq_prio_pkg

// ### logic/irq_prio_vector.sv
// interrupt priority resolver and vector generator with apb register slave
// assumes peripherals present level requests already qualified by their own flags
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module irq_prio_vector
    import irq_prio_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    input  wire logic                   first_mode_pin,
    input  wire logic                   second_mode_pin,
    input  wire logic                   irq_pin_n,
    input  wire logic [n_maskable-2:0]  periph_req,
    input  wire logic [n_maskable-2:0]  periph_enable,
    input  wire serial_req_t            serial_req,
    input  wire serial_en_t             serial_en,
    input  wire nmi_req_t               nmi_req,
    input  wire logic                   watchdog_disable,
    input  wire logic                   clock_monitor_enable,
    input  wire logic                   i_mask,
    input  wire logic                   x_mask,
    input  wire logic                   instr_done,
    input  wire logic                   cc_stacked,
    input  wire logic                   fetch_done,
    output logic                        set_i_mask,
    output logic                        set_x_mask,
    output vector_t                     vector_out,
    output logic                        read_visibility_enable,
    output logic                        irq_edge_mode
);

    // --------------------------------------------------------------------
    // registers
    // --------------------------------------------------------------------
    logic [3:0]  psel_reg;
    logic        boot_reg;
    logic        special_mode_reg;
    logic        mode_a_reg;
    logic        irv_reg;
    logic        strap_done_reg;
    vector_t     vec_reg;
    vector_t     vec_next;
    logic        hold_reg;

    logic        wr_en;
    logic        rd_en;
    logic        hit;
    logic [7:0]  misc_val;

    // the edge option lives elsewhere; this block always reports level mode
    assign irq_edge_mode          = 1'b0;
    assign read_visibility_enable = irv_reg;

    // --------------------------------------------------------------------
    // apb slave
    // --------------------------------------------------------------------
    assign pready  = 1'b1;
    assign hit     = (paddr == prio_misc_addr) || (paddr == status_addr) || (paddr == vector_addr);
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pslverr = psel && penable && !hit;
    assign misc_val = {boot_reg & special_mode_reg, special_mode_reg, mode_a_reg, irv_reg, psel_reg};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                prio_misc_addr: prdata <= {24'h0, misc_val};
                status_addr:    prdata <= {30'h0, x_mask, i_mask};
                vector_addr:    prdata <= {14'h0, vec_reg.valid, vec_reg.is_xpin, vec_reg.addr};
                default:        prdata <= 32'h0;
            endcase
        end
    end

    // select field only while maskable interrupts are inhibited
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel_reg <= psel_reset;
        end else if (wr_en && paddr == prio_misc_addr && i_mask) begin
            psel_reg <= pwdata[3:0];
        end
    end

    // mode bits are caught by the first clocked edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done_reg   <= 1'b0;
            special_mode_reg <= 1'b0;
            mode_a_reg       <= 1'b0;
            boot_reg         <= 1'b0;
            irv_reg          <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg   <= 1'b1;
            special_mode_reg <= !second_mode_pin;
            mode_a_reg       <= first_mode_pin;
            boot_reg         <= !second_mode_pin;
            irv_reg          <= !second_mode_pin;
        end else if (wr_en && paddr == prio_misc_addr) begin
            irv_reg  <= pwdata[irv_bit];
            boot_reg <= special_mode_reg ? pwdata[boot_bit] : 1'b0;
        end else if (!special_mode_reg) begin
            boot_reg <= 1'b0;
        end
    end

    // --------------------------------------------------------------------
    // arbitration
    // --------------------------------------------------------------------
    // select code to the source it promotes
    function automatic mask_src_t promoted(input logic [3:0] code);
        case (code)
            4'h0:    promoted = src_tovf;
            4'h1:    promoted = src_pa_ovf;
            4'h2:    promoted = src_pa_edge;
            4'h3:    promoted = src_spi;
            4'h4:    promoted = src_serial;
            4'h5:    promoted = src_irq;
            4'h6:    promoted = src_irq;
            4'h7:    promoted = src_rti;
            4'h8:    promoted = src_ic1;
            4'h9:    promoted = src_ic2;
            4'ha:    promoted = src_ic3;
            4'hb:    promoted = src_oc1;
            4'hc:    promoted = src_oc2;
            4'hd:    promoted = src_oc3;
            4'he:    promoted = src_oc4;
            default: promoted = src_ic4oc5;
        endcase
    endfunction : promoted

    function automatic logic [15:0] mask_vector(input mask_src_t s);
        case (s)
            src_irq:     mask_vector = vec_irq;
            src_rti:     mask_vector = vec_rti;
            src_ic1:     mask_vector = vec_ic1;
            src_ic2:     mask_vector = vec_ic2;
            src_ic3:     mask_vector = vec_ic3;
            src_oc1:     mask_vector = vec_oc1;
            src_oc2:     mask_vector = vec_oc2;
            src_oc3:     mask_vector = vec_oc3;
            src_oc4:     mask_vector = vec_oc4;
            src_ic4oc5:  mask_vector = vec_ic4oc5;
            src_tovf:    mask_vector = vec_tovf;
            src_pa_ovf:  mask_vector = vec_pa_ovf;
            src_pa_edge: mask_vector = vec_pa_edge;
            src_spi:     mask_vector = vec_spi;
            default:     mask_vector = vec_serial;
        endcase
    endfunction : mask_vector

    logic [n_maskable-1:0] mreq;
    logic                  serial_any;
    mask_src_t             prom;

    always_comb begin
        serial_any = (serial_req.tx_complete && serial_en.tx_complete_enable)
                   || (serial_req.tx_empty && serial_en.tx_empty_enable)
                   || (serial_req.idle_line && serial_en.idle_line_enable)
                   || ((serial_req.rx_overrun || serial_req.rx_full) && serial_en.rx_event_enable);
        // irq pin has no local enable and is active low level
        mreq = {serial_any, periph_req[n_maskable-2:1] & periph_enable[n_maskable-2:1], !irq_pin_n};
        prom = promoted(psel_reg);
    end

    always_comb begin
        vec_next = '0;
        if (nmi_req.reset_req) begin
            vec_next = '{1'b1, 1'b0, vec_reset};
        end else if (nmi_req.clock_fail && clock_monitor_enable) begin
            vec_next = '{1'b1, 1'b0, vec_clkmon};
        end else if (nmi_req.watchdog_timeout && !watchdog_disable) begin
            vec_next = '{1'b1, 1'b0, vec_watchdog};
        end else if (nmi_req.nonmaskable_pin_interrupt && !x_mask) begin
            vec_next = '{1'b1, 1'b1, vec_xpin};
        end else if (nmi_req.illegal_opcode) begin
            vec_next = '{1'b1, 1'b0, vec_illegal};
        end else if (nmi_req.software_trap) begin
            vec_next = '{1'b1, 1'b0, vec_swtrap};
        end else if (!i_mask) begin
            if (mreq[prom]) begin
                vec_next = '{1'b1, 1'b0, mask_vector(prom)};
            end else begin
                for (int k = n_maskable - 1; k >= 0; k--) begin
                    if (mreq[k]) begin
                        vec_next = '{1'b1, 1'b0, mask_vector(mask_src_t'(k[3:0]))};
                    end
                end
            end
        end
    end

    // --------------------------------------------------------------------
    // vector hand-over to the core
    // --------------------------------------------------------------------
    // the vector freezes from instruction completion until the fetch ends, so a
    // late higher request cannot tear the two vector bytes apart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg <= 1'b0;
            vec_reg  <= '0;
        end else if (hold_reg) begin
            if (fetch_done) begin
                hold_reg <= 1'b0;
            end
        end else if (instr_done && vec_next.valid) begin
            hold_reg <= 1'b1;
            vec_reg  <= vec_next;
        end else begin
            vec_reg  <= vec_next;
        end
    end

    assign vector_out = vec_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_i_mask <= 1'b0;
            set_x_mask <= 1'b0;
        end else begin
            set_i_mask <= hold_reg && cc_stacked;
            set_x_mask <= hold_reg && cc_stacked && vec_reg.is_xpin;
        end
    end

endmodule : irq_prio_vector

// ### testbench/irq_prio_vector_chk.sv
// checker for the interrupt priority and vectoring block
// bound to the block's top module; watches its ports only
`timescale 1ns/1ns
module irq_prio_vector_chk
    import irq_prio_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire nmi_req_t    nmi_req,
    input wire logic        i_mask,
    input wire logic        x_mask,
    input wire logic        instr_done,
    input wire logic        cc_stacked,
    input wire logic        fetch_done,
    input wire logic        set_i_mask,
    input wire logic        set_x_mask,
    input wire vector_t     vector_out,
    input wire logic        read_visibility_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // mirrors the service freeze so live-vector checks skip it
    logic held_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) held_reg <= 1'b0;
        else if (fetch_done) held_reg <= 1'b0;
        else if (instr_done && vector_out.valid) held_reg <= 1'b1;
    end
    property p_slverr; psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}); endproperty
    a_slverr: assert property (p_slverr) else $error("bad slave error");
    property p_rv; psel && penable && pwrite && paddr == 8'h00 |=> read_visibility_enable == $past(pwdata[4]); endproperty
    a_rv: assert property (p_rv) else $error("visibility not written");
    property p_rst; nmi_req.reset_req && !held_reg |=> vector_out.valid && vector_out.addr == 16'hfffe; endproperty
    a_rst: assert property (p_rst) else $error("reset not first");
    property p_xm; nmi_req.nonmaskable_pin_interrupt && x_mask && !held_reg |=> !vector_out.is_xpin; endproperty
    a_xm: assert property (p_xm) else $error("pin interrupt not masked");
    property p_im; i_mask && nmi_req == '0 && !held_reg |=> !vector_out.valid; endproperty
    a_im: assert property (p_im) else $error("maskable while masked");
    property p_trap; nmi_req.software_trap && !held_reg |=> vector_out.valid; endproperty
    a_trap: assert property (p_trap) else $error("trap masked");
    property p_hold; held_reg && $past(held_reg) && !$past(fetch_done) |-> $stable(vector_out); endproperty
    a_hold: assert property (p_hold) else $error("vector moved in service");
    property p_pulse; cc_stacked && held_reg |=> set_i_mask && set_x_mask == $past(vector_out.is_xpin); endproperty
    a_pulse: assert property (p_pulse) else $error("mask set pulse wrong");
    property p_cause; set_i_mask |-> $past(cc_stacked); endproperty
    a_cause: assert property (p_cause) else $error("stray mask pulse");
endmodule : irq_prio_vector_chk

// ### testbench/cpu_core_model.sv
// core model: takes a vector on request, stacks, then fetches
// slow stretches the gaps; records mask pulses and the fetched vector
`timescale 1ns/1ns
module cpu_core_model
    import irq_prio_pkg::*;
(
    input  wire logic    pclk,
    input  wire logic    go,
    input  wire logic    slow,
    input  wire vector_t vector_out,
    input  wire logic    set_i_mask,
    input  wire logic    set_x_mask,
    output logic         instr_done,
    output logic         cc_stacked,
    output logic         fetch_done,
    output logic         saw_i,
    output logic         saw_x,
    output logic         busy,
    output logic [15:0]  taken
);
    initial begin
        {instr_done, cc_stacked, fetch_done, saw_i, saw_x, busy, taken} = '0;
        forever begin
            @(posedge pclk);
            if (go && vector_out.valid) begin
                busy <= 1'b1;
                {saw_i, saw_x} <= 2'b00;
                instr_done <= 1'b1;
                @(posedge pclk) instr_done <= 1'b0;
                repeat (slow ? 6 : 1) @(posedge pclk);
                cc_stacked <= 1'b1;
                @(posedge pclk) cc_stacked <= 1'b0;
                repeat (slow ? 5 : 3) begin
                    @(posedge pclk);
                    if (set_i_mask) saw_i <= 1'b1;
                    if (set_x_mask) saw_x <= 1'b1;
                end
                taken <= vector_out.addr;
                fetch_done <= 1'b1;
                @(posedge pclk) fetch_done <= 1'b0;
                busy <= 1'b0;
            end
        end
    end
endmodule : cpu_core_model

// ### testbench/tb_irq_prio_vector.sv
// self-checking bench: apb register access, random arbitration, service
// expects the block, its checker and the core model to compile alongside
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; $display("mismatch %0t %h %h", $time, a, b); end end
module tb_irq_prio_vector
    import irq_prio_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, go, slow, saw_i, saw_x, busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, r;
    logic [17:0] ev;
    logic first_mode_pin, second_mode_pin, irq_pin_n, watchdog_disable, clock_monitor_enable, i_mask, x_mask;
    logic [n_maskable-2:0] periph_req, periph_enable;
    serial_req_t serial_req;
    serial_en_t serial_en;
    nmi_req_t nmi_req;
    vector_t vector_out;
    logic instr_done, cc_stacked, fetch_done, set_i_mask, set_x_mask, read_visibility_enable, irq_edge_mode;
    logic [15:0] taken;
    int miscompares, samples_checked;
    irq_prio_vector irq_prio_vector_inst (.*);
    cpu_core_model cpu_core_model_inst (.*);
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done;
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic wait_on(ref logic s, input logic v);
        int n;
        n = 0;
        do begin @(posedge pclk); n++; end while (s !== v && n < 40);
        if (n >= 40) begin miscompares++; test_done(); end
    endtask : wait_on
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        wait_on(pready, 1'b1);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(rd & m, x)
        `CHK(er, 1'b0)
    endtask : rdc
    task automatic do_reset(input logic a, input logic b);
        presetn <= 0; first_mode_pin <= a; second_mode_pin <= b;
        repeat (16) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        first_mode_pin <= ~a; // later pin moves must not reach the mode bits
    endtask : do_reset
    task automatic serve(input logic s, input logic [15:0] ex, input logic xx);
        slow <= s; go <= 1;
        wait_on(busy, 1'b1);
        go <= 0; nmi_req <= 6'b100000; // a late reset request must not disturb the fetch
        wait_on(busy, 1'b0);
        `CHK(taken, ex)
        `CHK({saw_i, saw_x}, {1'b1, xx})
        repeat (2) @(posedge pclk);
        `CHK(vector_out.addr, 16'hfffe)
        nmi_req <= '0;
    endtask : serve
    function automatic logic [31:0] rnd();
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // behavioural arbiter: {valid, is_xpin, addr}
    function automatic logic [17:0] exp_vec(input int c);
        logic [14:0] m;
        int w;
        m = {|(serial_req[4:2] & serial_en[3:1]) | (|serial_req[1:0] & serial_en[0]),
             periph_req[13:1] & periph_enable[13:1], !irq_pin_n};
        w = c > 7 ? c - 6 : c == 7 ? 1 : c < 5 ? c + 10 : 0;
        if (nmi_req.reset_req) return {2'b10, 16'hfffe};
        if (nmi_req.clock_fail && clock_monitor_enable) return {2'b10, 16'hfffc};
        if (nmi_req.watchdog_timeout && !watchdog_disable) return {2'b10, 16'hfffa};
        if (nmi_req.nonmaskable_pin_interrupt && !x_mask) return {2'b11, 16'hfff4};
        if (nmi_req.illegal_opcode) return {2'b10, 16'hfff8};
        if (nmi_req.software_trap) return {2'b10, 16'hfff6};
        if (i_mask) return '0;
        if (!m[w]) begin w = 0; while (w < 15 && !m[w]) w++; end
        return w < 15 ? {2'b10, 16'hfff2 - 16'(2 * w)} : '0;
    endfunction : exp_vec
    initial begin
        seed = 32'h5042; miscompares = 0; samples_checked = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; first_mode_pin = 0; second_mode_pin = 0; irq_pin_n = 1; periph_req = 0;
        periph_enable = 0; serial_req = 0; serial_en = 0; nmi_req = 0; watchdog_disable = 0;
        clock_monitor_enable = 0; i_mask = 1; x_mask = 1; go = 0; slow = 0;
        do_reset(1'b1, 1'b0);
        rdc(8'h00, 32'hff, 32'hf5);
        `CHK({read_visibility_enable, irq_edge_mode}, 2'b10)
        apb(1'b1, 8'h00, 32'h05);
        rdc(8'h00, 32'hff, 32'h65);
        apb(1'b1, 8'h00, 32'h80);
        rdc(8'h00, 32'hff, 32'he0);
        do_reset(1'b0, 1'b1);
        rdc(8'h00, 32'hff, 32'h05);
        apb(1'b1, 8'h00, 32'h9a);
        rdc(8'h00, 32'hff, 32'h1a);
        `CHK(read_visibility_enable, 1'b1)
        i_mask <= 1'b0;
        apb(1'b1, 8'h00, 32'h13);
        rdc(8'h00, 32'h0f, 32'h0a);
        rdc(8'h04, 32'h03, 32'h02);
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(er, 1'b1)
        for (int i = 0; i < 160; i++) begin
            i_mask <= 1;
            apb(1'b1, 8'h00, 32'(i % 16));
            r = rnd(); irq_pin_n <= r[0]; periph_req <= r[14:1]; periph_enable <= r[28:15];
            i_mask <= r[29] & r[30]; x_mask <= r[31];
            r = rnd(); serial_req <= r[4:0]; serial_en <= r[8:5]; watchdog_disable <= r[9];
            clock_monitor_enable <= r[10]; nmi_req <= r[16:11] & r[22:17] & r[28:23];
            repeat (2) @(posedge pclk);
            ev = exp_vec(i % 16);
            `CHK(vector_out.valid, ev[17])
            if (ev[17]) `CHK(vector_out[16:0], ev[16:0])
        end
        nmi_req <= 6'b000100; x_mask <= 0; i_mask <= 1;
        repeat (2) @(posedge pclk);
        serve(1'b0, 16'hfff4, 1'b1);
        irq_pin_n <= 1'b0; i_mask <= 1'b0; periph_enable <= '0; serial_en <= '0;
        repeat (2) @(posedge pclk);
        serve(1'b1, 16'hfff2, 1'b0);
        repeat (2) @(posedge pclk);
        rdc(8'h08, 32'h3ffff, 32'h2fff2);
        test_done();
    end
endmodule : tb_irq_prio_vector
bind irq_prio_vector irq_prio_vector_chk irq_prio_vector_chk_inst (.*);
